// File: core/cg_clock_gen.sv
// Dual-loop clock generator with AHB-Lite control registers
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module cg_clock_gen (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reference_input_clock,
  output logic full_rate_domain,
  output logic transfer_clock,
  output logic video_input_path,
  output logic video_output_path,
  output logic observe_clock_pin,
  output logic memory_clock,
  output logic video_output_path_alt,
  output logic impedance_calibration,
  output logic half_rate_domain,
  output logic third_rate_domain,
  output logic sixth_rate_domain
);
  localparam int RW = cg_pkg::RAT_W;
  localparam int PW = cg_pkg::PER_W;

  // Reference pin synchroniser and edge history
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic ref_edge; // Either edge: one half period of reference
  logic ref_rise;
  // Period measurement
  logic [PW-1:0] pcnt_q;   // Cycles since last rising edge
  logic [PW-1:0] period_q; // Last measured period
  logic seen_q;            // One rising edge has been seen
  logic lock_q;            // Period is valid
  // Loop phase accumulators
  logic [PW-1:0] acc1_q, acc2_q;
  logic tick1_q, tick2_q;  // Loop half-period pulses
  // Software registers
  logic [cg_pkg::MULT_W-1:0] mult1_q, mult2_q;
  logic [cg_pkg::NUM_PROG*RW-1:0] div_q;
  // Bus phase state
  logic wr_q;           // Write data phase pending
  logic rd_q;           // Read data phase, first cycle
  logic rd_done_q;      // Read data ready
  logic [7:0] addr_q;   // Latched byte address
  logic accept;
  logic ratio_ok;

  cg_div_if #(.N(cg_pkg::NUM_CH), .RW(RW)) dv ();

  // Loop step: add twice the factor, emit a tick when a period is spanned
  function automatic logic [PW:0] loop_step(
    input logic [PW-1:0] acc,
    input logic [cg_pkg::MULT_W-1:0] mult,
    input logic [PW-1:0] per
  );
    logic [PW-1:0] sum;
    sum = acc + PW'({mult, 1'b0});
    if (sum >= per)
      return {1'b1, PW'(sum - per)};
    return {1'b0, sum};
  endfunction : loop_step

  // Divider field of programmable channel i
  function automatic logic [RW-1:0] dfield(input int i,
    input logic [cg_pkg::NUM_PROG*RW-1:0] d);
    return d[i*RW +: RW];
  endfunction : dfield

  // Two-flop synchroniser, third flop only for edge detect
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end
    else
    begin
      ref_s1_q <= reference_input_clock;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end
  assign ref_edge = ref_s2_q ^ ref_s3_q;
  assign ref_rise = ref_s2_q & ~ref_s3_q;

  // Reference period measurement and lock
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pcnt_q <= '0;
      period_q <= '0;
      seen_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (ref_rise)
    begin
      pcnt_q <= '0;
      period_q <= pcnt_q + 1'b1;
      seen_q <= 1'b1;
      lock_q <= seen_q;
    end
    else if (&pcnt_q)
    begin
      // Reference stopped: drop lock
      seen_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      pcnt_q <= pcnt_q + 1'b1;
    end
  end

  // First and second loop tick generation
  always_ff @(posedge mclk)
  begin
    if (rst || !lock_q)
    begin
      acc1_q <= '0;
      acc2_q <= '0;
      tick1_q <= 1'b0;
      tick2_q <= 1'b0;
    end
    else
    begin
      {tick1_q, acc1_q} <= loop_step(acc1_q, mult1_q, period_q);
      {tick2_q, acc2_q} <= loop_step(acc2_q, mult2_q, period_q);
    end
  end

  // Divider sources and ratios
  always_comb
  begin
    dv.tick = '0;
    dv.ratio = '0;
    for (int i = 0; i < cg_pkg::NUM_PROG; i++)
      dv.ratio[i*RW +: RW] = dfield(i, div_q);
    dv.tick[cg_pkg::CH_FULL] = tick1_q;
    dv.tick[cg_pkg::CH_XFER] = tick1_q;
    dv.tick[cg_pkg::CH_VIN] = tick1_q;
    dv.tick[cg_pkg::CH_VOUT] = ref_edge;
    dv.tick[cg_pkg::CH_OBS] = ref_edge;
    dv.tick[cg_pkg::CH_MEM] = tick2_q;
    dv.tick[cg_pkg::CH_VOUT2] = tick2_q;
    dv.tick[cg_pkg::CH_CAL] = ref_edge;
    // Derived domains count half periods of the full-rate clock
    dv.tick[cg_pkg::CH_HALF] = dv.tog[cg_pkg::CH_FULL];
    dv.tick[cg_pkg::CH_THIRD] = dv.tog[cg_pkg::CH_FULL];
    dv.tick[cg_pkg::CH_SIXTH] = dv.tog[cg_pkg::CH_FULL];
    dv.ratio[cg_pkg::CH_HALF*RW +: RW] = cg_pkg::RAT_HALF;
    dv.ratio[cg_pkg::CH_THIRD*RW +: RW] = cg_pkg::RAT_THIRD;
    dv.ratio[cg_pkg::CH_SIXTH*RW +: RW] = cg_pkg::RAT_SIXTH;
  end

  cg_divider #(.N(cg_pkg::NUM_CH), .RW(RW)) u_div (
    .mclk(mclk),
    .rst(rst),
    .dv(dv)
  );

  // Clock outputs
  assign full_rate_domain = dv.clk[cg_pkg::CH_FULL];
  assign transfer_clock = dv.clk[cg_pkg::CH_XFER];
  assign video_input_path = dv.clk[cg_pkg::CH_VIN];
  assign video_output_path = dv.clk[cg_pkg::CH_VOUT];
  assign observe_clock_pin = dv.clk[cg_pkg::CH_OBS];
  assign memory_clock = dv.clk[cg_pkg::CH_MEM];
  assign video_output_path_alt = dv.clk[cg_pkg::CH_VOUT2];
  assign impedance_calibration = dv.clk[cg_pkg::CH_CAL];
  assign half_rate_domain = dv.clk[cg_pkg::CH_HALF];
  assign third_rate_domain = dv.clk[cg_pkg::CH_THIRD];
  assign sixth_rate_domain = dv.clk[cg_pkg::CH_SIXTH];

  // Status check: transfer and video-input ratios are 3x and 6x core
  assign ratio_ok =
    (8'(dfield(cg_pkg::CH_XFER, div_q)) + 8'h01)
      == 8'(3 * (8'(dfield(cg_pkg::CH_FULL, div_q)) + 8'h01))
    && (8'(dfield(cg_pkg::CH_VIN, div_q)) + 8'h01)
      == 8'(6 * (8'(dfield(cg_pkg::CH_FULL, div_q)) + 8'h01));

  // AHB-Lite: take a transfer in its address phase
  assign accept = hsel && htrans[1] && hready;
  assign hresp = 1'b0;
  // Reads wait one cycle so a preceding write is seen
  assign hreadyout = !rd_q;

  // Bus phase tracking
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      if (hready)
      begin
        wr_q <= accept && hwrite;
        rd_q <= accept && !hwrite;
        if (accept)
          addr_q <= haddr[7:0];
      end
      else
      begin
        rd_q <= 1'b0;
      end
    end
  end

  // Register writes in the data phase; reset defaults persist
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mult1_q <= cg_pkg::MULT_DEF;
      mult2_q <= cg_pkg::MULT_DEF;
      div_q <= cg_pkg::DIV_DEF;
    end
    else if (wr_q)
    begin
      if (addr_q == cg_pkg::OFS_MULT1)
        mult1_q <= hwdata[cg_pkg::MULT_W-1:0];
      else if (addr_q == cg_pkg::OFS_MULT2)
        mult2_q <= hwdata[cg_pkg::MULT_W-1:0];
      else
      begin
        // Divider registers, one word each
        for (int i = 0; i < cg_pkg::NUM_PROG; i++)
          if (addr_q == cg_pkg::OFS_DIV0 + 8'(4 * i))
            div_q[i*RW +: RW] <= hwdata[RW-1:0];
      end
    end
  end

  // Read data, loaded in the wait cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hrdata <= '0;
      rd_done_q <= 1'b0;
    end
    else
    begin
      rd_done_q <= rd_q;
      if (rd_q)
      begin
        hrdata <= '0;
        if (addr_q == cg_pkg::OFS_MULT1)
          hrdata[cg_pkg::MULT_W-1:0] <= mult1_q;
        else if (addr_q == cg_pkg::OFS_MULT2)
          hrdata[cg_pkg::MULT_W-1:0] <= mult2_q;
        else if (addr_q == cg_pkg::OFS_STATUS)
        begin
          hrdata[cg_pkg::ST_LOCK] <= lock_q;
          hrdata[cg_pkg::ST_RATIO] <= ratio_ok;
          hrdata[cg_pkg::ST_PER_LSB +: PW] <= period_q;
        end
        else
        begin
          for (int i = 0; i < cg_pkg::NUM_PROG; i++)
            if (addr_q == cg_pkg::OFS_DIV0 + 8'(4 * i))
              hrdata[RW-1:0] <= dfield(i, div_q);
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  loop_tick_lock_a: assert property (tick1_q |-> $past(lock_q))
    else $error("first loop ticked without lock");
  core_div_src_a: assert property ($changed(full_rate_domain)
    |-> $past(tick1_q))
    else $error("core clock moved without a loop tick");
  vout_bypass_a: assert property ($changed(video_output_path)
    |-> $past(ref_edge))
    else $error("video output clock moved without reference edge");
  observe_pin_a: assert property ($changed(observe_clock_pin)
    |-> $past(ref_edge))
    else $error("observe pin moved without reference edge");
  mem_loop_a: assert property ($changed(memory_clock)
    |-> $past(tick2_q))
    else $error("memory clock moved without second loop tick");
  cal_bypass_a: assert property ($changed(impedance_calibration)
    |-> $past(ref_edge))
    else $error("calibration clock moved without reference edge");
  half_rate_a: assert property (dv.tog[cg_pkg::CH_FULL]
    && u_div.cnt_q[cg_pkg::CH_HALF] == cg_pkg::RAT_HALF
    |=> $changed(half_rate_domain))
    else $error("half rate domain missed its toggle");
  reset_default_a: assert property ($past(rst) && !wr_q
    |-> div_q == cg_pkg::DIV_DEF && mult1_q == cg_pkg::MULT_DEF
      && mult2_q == cg_pkg::MULT_DEF)
    else $error("defaults not loaded after reset");
endmodule : cg_clock_gen

// File: core/cg_pkg.sv
// Constants shared by the dual-loop clock generator files
package cg_pkg;
  localparam int MULT_W = 6;   // Loop multiply field width
  localparam int RAT_W = 5;    // Divider field: ratio minus one
  localparam int PER_W = 16;   // Reference period counter width
  localparam int NUM_PROG = 8; // Software divider channels
  localparam int NUM_CH = 11;  // Programmable plus fixed derived channels
  // Channel numbers
  localparam int CH_FULL = 0;  // Processor core clock
  localparam int CH_XFER = 1;  // Transfer engine clock
  localparam int CH_VIN = 2;   // Video input path clock
  localparam int CH_VOUT = 3;  // Video output path, bypass
  localparam int CH_OBS = 4;   // Observe clock pin
  localparam int CH_MEM = 5;   // Memory interface clock
  localparam int CH_VOUT2 = 6; // Video output path, second loop
  localparam int CH_CAL = 7;   // Impedance calibration clock
  localparam int CH_HALF = 8;  // Half rate domain
  localparam int CH_THIRD = 9; // Third rate domain
  localparam int CH_SIXTH = 10; // Sixth rate domain
  // Register byte offsets
  localparam logic [7:0] OFS_MULT1 = 8'h00;
  localparam logic [7:0] OFS_MULT2 = 8'h04;
  localparam logic [7:0] OFS_DIV0 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // Status bit positions
  localparam int ST_LOCK = 0;
  localparam int ST_RATIO = 2;
  localparam int ST_PER_LSB = 16;
  // Reset values, divider fields hold ratio minus one
  localparam logic [MULT_W-1:0] MULT_DEF = 6'h01;
  localparam logic [NUM_PROG*RAT_W-1:0] DIV_DEF =
    {5'h01, 5'h09, 5'h01, 5'h00, 5'h00, 5'h05, 5'h02, 5'h00};
  // Fixed derived-domain fields: divide by 2, 3 and 6
  localparam logic [RAT_W-1:0] RAT_HALF = 5'h01;
  localparam logic [RAT_W-1:0] RAT_THIRD = 5'h02;
  localparam logic [RAT_W-1:0] RAT_SIXTH = 5'h05;
endpackage : cg_pkg

// File: core/cg_div_if.sv
// Carrier between tick sources and the divider bank
`timescale 1ns/1ps
interface cg_div_if #(parameter int N = 11, parameter int RW = 5);
  logic [N-1:0] tick;     // Half-period pulses of each source
  logic [N*RW-1:0] ratio; // Divide field per channel, ratio minus one
  logic [N-1:0] tog;      // Pulse when a channel output toggles
  logic [N-1:0] clk;      // Divided clock levels
  modport src (output tick, output ratio, input tog, input clk);
  modport div (input tick, input ratio, output tog, output clk);
endinterface : cg_div_if

// File: core/cg_divider.sv
// Bank of programmable half-period dividers
`timescale 1ns/1ps
module cg_divider #(
  parameter int N = 11,
  parameter int RW = 5
) (
  input wire logic mclk,
  input wire logic rst,
  cg_div_if.div dv
);
  logic [RW-1:0] cnt_q [N]; // Ticks seen in the current half period
  logic [N-1:0] tog_q;      // Toggle pulse
  logic [N-1:0] clk_q;      // Output level

  // Count ticks, toggle output after ratio plus one ticks
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst)
      begin
        cnt_q[i] <= '0;
        tog_q[i] <= 1'b0;
        clk_q[i] <= 1'b0;
      end
      else if (dv.tick[i])
      begin
        // Half period complete
        if (cnt_q[i] >= dv.ratio[i*RW +: RW])
        begin
          cnt_q[i] <= '0;
          tog_q[i] <= 1'b1;
          clk_q[i] <= ~clk_q[i];
        end
        else
        begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
          tog_q[i] <= 1'b0;
        end
      end
      else
      begin
        tog_q[i] <= 1'b0;
      end
    end
  end

  assign dv.tog = tog_q;
  assign dv.clk = clk_q;

  // Counter stays in range unless ratio just dropped
  for (genvar g = 0; g < N; g++)
  begin : g_chk
    cnt_bound_a: assert property (@(posedge mclk) disable iff (rst)
      $stable(dv.ratio[g*RW +: RW]) && dv.tick[g]
      && cnt_q[g] == dv.ratio[g*RW +: RW] |=> cnt_q[g] == '0 && tog_q[g])
      else $error("divider did not wrap at its ratio");
  end
endmodule : cg_divider

// File: dv/cg_consumer.sv
// Consumer model that counts rising edges of each generated clock
`timescale 1ns/1ps
module cg_consumer #(
  parameter int N = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [N-1:0] clk_in,
  output logic [N*16-1:0] cnt
);
  logic [N-1:0] prev_q; // Clock levels one cycle back
  // Count rising edges while the window is open
  always_ff @(posedge mclk)
  begin
    prev_q <= clk_in;
    for (int i = 0; i < N; i++)
    begin
      if (rst || clr)
        cnt[i*16 +: 16] <= 16'h0000;
      else if (en && clk_in[i] && !prev_q[i])
        cnt[i*16 +: 16] <= cnt[i*16 +: 16] + 16'h0001;
    end
  end
endmodule : cg_consumer

// File: dv/testbench.sv
// Self-checking bench for the dual-loop clock generator
`timescale 1ns/1ps
module testbench;
  localparam int W = 10000; // Measurement window in cycles
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic ref_clk = 1'b0; // Reference pin, 20 cycle period
  logic [4:0] ref_cnt = 5'h00;
  logic [10:0] clks; // Generated clocks by channel number
  logic clr = 1'b0;
  logic en = 1'b0;
  logic [175:0] cnt;
  logic [31:0] rd;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h0a94e31c;
  int m1;
  int m2;
  int dv [8]; // Divider fields in use
  // Clock, single slave bus, reference pin
  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  always @(posedge mclk)
  begin
    ref_cnt <= (ref_cnt == 5'h09) ? 5'h00 : ref_cnt + 5'h01;
    if (ref_cnt == 5'h09)
      ref_clk <= ~ref_clk;
  end
  cg_clock_gen dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata),
    .reference_input_clock(ref_clk),
    .full_rate_domain(clks[0]), .transfer_clock(clks[1]),
    .video_input_path(clks[2]), .video_output_path(clks[3]),
    .observe_clock_pin(clks[4]), .memory_clock(clks[5]),
    .video_output_path_alt(clks[6]),
    .impedance_calibration(clks[7]), .half_rate_domain(clks[8]),
    .third_rate_domain(clks[9]), .sixth_rate_domain(clks[10])
  );
  cg_consumer #(.N(11)) sink (
    .mclk(mclk), .rst(rst), .clr(clr), .en(en), .clk_in(clks),
    .cnt(cnt)
  );
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Counts, verdict and end of run
  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Bounded wait for a rising edge that samples hready high
  task wait_rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100)
    begin
      failures++;
      finish_test();
    end
  endtask : wait_rdy
  // One single word transfer, address then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : xfer
  // Rising edges expected in one window
  function automatic int exp_edges(int ch);
    int f;
    int m;
    int k;
    f = (ch < 8) ? dv[ch] : dv[0];
    m = (ch < 3 || ch > 7) ? m1 : ((ch == 5 || ch == 6) ? m2 : 1);
    k = (ch == 8) ? 2 : ((ch == 9) ? 3 : ((ch == 10) ? 6 : 1));
    return W * m / (20 * (f + 1) * k);
  endfunction : exp_edges
  // Status word: period 20, ratio check, lock
  function automatic logic [31:0] exp_stat();
    logic ok;
    ok = (dv[1] + 1 == 3 * (dv[0] + 1)) && (dv[2] + 1 == 6 * (dv[0] + 1));
    return {16'h0014, 13'h0000, ok, 1'b0, 1'b1};
  endfunction : exp_stat
  // Edge count within tolerance maps to the expectation
  function automatic int near(int s, int e);
    int t;
    t = 2 + e / 50;
    return (s - e <= t && e - s <= t) ? e : s;
  endfunction : near
  // Program multipliers and dividers, junk in upper bits
  task set_cfg;
    xfer(1'b1, 32'h0, ($random(seed) & ~32'h3f) | m1, rd);
    xfer(1'b1, 32'h4, ($random(seed) & ~32'h3f) | m2, rd);
    for (int i = 0; i < 8; i++)
      xfer(1'b1, 32'h8 + 4 * i, ($random(seed) & ~32'h1f) | dv[i], rd);
  endtask : set_cfg
  // Read back all registers, then measure every clock
  task check_all;
    xfer(1'b0, 32'h0, 32'h0, rd);
    check(rd, m1);
    xfer(1'b0, 32'h4, 32'h0, rd);
    check(rd, m2);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, 32'h8 + 4 * i, 32'h0, rd);
      check(rd, dv[i]);
    end
    xfer(1'b0, 32'h28, 32'h0, rd);
    check(rd, exp_stat());
    repeat (1000) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    en <= 1'b1;
    repeat (W) @(posedge mclk);
    en <= 1'b0;
    @(posedge mclk);
    for (int c = 0; c < 11; c++)
      check(near(cnt[c*16 +: 16], exp_edges(c)), exp_edges(c));
    $display("test done m1 %0d m2 %0d", m1, m2);
  endtask : check_all
  // Main sequence
  initial
  begin
    m1 = 1;
    m2 = 1;
    dv = '{0, 2, 5, 0, 0, 1, 9, 1};
    repeat (20) @(posedge mclk);
    check({21'h0, clks}, 32'h0);
    rst <= 1'b0;
    repeat (100) @(posedge mclk);
    // Stray writes to status and unmapped words leave defaults alone
    xfer(1'b1, 32'h28, 32'hffffffff, rd);
    xfer(1'b1, 32'h30, 32'hffffffff, rd);
    xfer(1'b0, 32'h30, 32'h0, rd);
    check(rd, 32'h0);
    check_all();
    // Software keeps 1:3:6, extreme divider fields elsewhere
    m1 = 4;
    m2 = 7;
    dv = '{1, 5, 11, 31, 0, 31, 0, 3};
    set_cfg();
    check_all();
    for (int r = 0; r < 3; r++)
    begin
      m1 = {$random(seed)} % 10 + 1;
      m2 = {$random(seed)} % 10 + 1;
      foreach (dv[i])
        dv[i] = {$random(seed)} % 32;
      set_cfg();
      check_all();
    end
    // Second reset restores the defaults
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    check({21'h0, clks}, 32'h0);
    rst <= 1'b0;
    m1 = 1;
    m2 = 1;
    dv = '{0, 2, 5, 0, 0, 1, 9, 1};
    repeat (100) @(posedge mclk);
    check_all();
    finish_test();
  end
endmodule : testbench
